// >>> design/irq_ctrl_defs.svh
// Register offsets, reset values, field positions and vectors of the
// interrupt controller. Included by the package and the design modules.
`ifndef IRQ_CTRL_DEFS_SVH
`define IRQ_CTRL_DEFS_SVH

// Register byte offsets on the 8-bit register port.
`define OFS_IRQ_ENABLE_MAIN 8'ha8
`define OFS_IRQ_ENABLE_PRIORITY_SECOND 8'ha9
`define OFS_IRQ_PRIORITY_MAIN 8'hb8
`define OFS_WATCHDOG_CONTROL 8'hc0

// Reset values.
`define RST_IRQ_ENABLE_MAIN 8'h00
`define RST_IRQ_ENABLE_PRIORITY_SECOND 8'ha0
`define RST_IRQ_PRIORITY_MAIN 8'h00
`define RST_WATCHDOG_CONTROL 8'h10

// Bit-address window bases for the bit-addressable registers.
`define BITBASE_ENABLE_MAIN 8'ha8
`define BITBASE_PRIORITY_MAIN 8'hb8
`define BITBASE_WATCHDOG 8'hc0

// Main enable register fields.
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_TIMER2_IRQ_ENABLE 5
`define BIT_UART_IRQ_ENABLE 4
`define BIT_TIMER1_IRQ_ENABLE 3
`define BIT_EXT1_IRQ_ENABLE 2
`define BIT_TIMER0_IRQ_ENABLE 1
`define BIT_EXT0_IRQ_ENABLE 0

// Main priority register fields.
`define BIT_METER_IRQ_PRIORITY 7
`define BIT_TIMER2_IRQ_PRIORITY 5
`define BIT_UART_IRQ_PRIORITY 4
`define BIT_TIMER1_IRQ_PRIORITY 3
`define BIT_EXT1_IRQ_PRIORITY 2
`define BIT_TIMER0_IRQ_PRIORITY 1
`define BIT_EXT0_IRQ_PRIORITY 0

// Second enable and priority register fields.
`define BIT_RTC_IRQ_PRIORITY 6
`define BIT_SERIAL_PORT_IRQ_PRIORITY 4
`define BIT_METER_IRQ_ENABLE 3
`define BIT_RTC_IRQ_ENABLE 2
`define BIT_POWER_MGMT_IRQ_ENABLE 1
`define BIT_SERIAL_PORT_IRQ_ENABLE 0

// Writable masks: reserved bits stay at zero, except the second register
// whose reserved upper bits hold their reset pattern.
`define MASK_ENABLE_MAIN 8'hbf
`define MASK_PRIORITY_MAIN 8'hbf
`define MASK_ENABLE_PRIORITY_SECOND 8'h5f
`define FIXED_ENABLE_PRIORITY_SECOND 8'ha0

// Vector addresses.
`define VEC_EXT0 16'h0003
`define VEC_TIMER0 16'h000b
`define VEC_EXT1 16'h0013
`define VEC_TIMER1 16'h001b
`define VEC_UART 16'h0023
`define VEC_TIMER2 16'h002b
`define VEC_SERIAL_PORT 16'h003b
`define VEC_POWER_MGMT 16'h0043
`define VEC_METER 16'h004b
`define VEC_RTC 16'h0053
`define VEC_WATCHDOG 16'h005b

// Number of sources.
`define NUM_SOURCES 12

`endif

// >>> design/irq_ctrl_pkg.sv
// Types shared by the interrupt controller modules.
// Assumes the constants header sits beside it.
`include "irq_ctrl_defs.svh"
package irq_ctrl_pkg;

  // Source index equals the polling order, first to last.
  typedef enum logic [3:0] {
    src_power_mgmt,
    src_rtc,
    src_meter,
    src_watchdog,
    src_ext0,
    src_timer0,
    src_ext1,
    src_timer1,
    src_serial_port,
    src_uart,
    src_timer2,
    src_none
  } irq_src_t;

  // Priority levels from low to top.
  typedef enum logic [1:0] {
    lvl_low,
    lvl_high,
    lvl_top
  } irq_level_t;

  // Vector handshake states.
  typedef enum logic [1:0] {
    st_idle,
    st_offer,
    st_block
  } vec_state_t;

endpackage

// >>> design/irq_pick.sv
// Fixed-order picker: lowest set index of a request vector wins.
// Assumes inputs come from logic on the same clock; purely combinational.
`include "irq_ctrl_defs.svh"
module irq_pick (
  // Requests in polling order.
  input wire logic [10:0] req,
  // Winner.
  output logic found,
  output irq_ctrl_pkg::irq_src_t winner
);
  import irq_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Scan from the last index down so the first set index is kept.
  always_comb begin
    found = 1'b0;
    winner = src_none;
    for (int i = 10; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        winner = irq_src_t'(i[3:0]);
      end
    end
  end
endmodule

// >>> design/irq_ctrl.sv
// Prioritized interrupt controller: enables, priorities, arbitration,
// vector offer and nesting of active service levels.
// Assumes sources are synchronous levels on clk and the core acknowledges
// an offered vector with a one-cycle pulse and signals each return.
//
// What this block does
// R1: Take twelve sources and arbitrate across three priority levels; eleven source inputs are wired here.
// R2: Power management alone is top level and preempts any routine.
// R3: Other sources go high or low by bits in two priority registers.
// R4: A high-level request may preempt a running low-level routine.
// R5: Of simultaneous requests, the higher level is presented first.
// R6: No request preempts a routine at its own level; it stays pending.
// R7: Within a level a fixed polling order decides.
// R8: Main enable bit 7 is global; cleared, nothing is presented.
// R9: Main enable holds per-source enables for timers, UART, externals.
// R10: Software keeps reserved bit 6 of enable and priority cleared.
// R11: Priority register holds one high/low bit per classic source.
// R12: Second register selects RTC and SPI/I2C priority at bits 6, 4.
// R13: Second register enables meter, RTC, power management, SPI/I2C.
// R14: Second register byte access only; others also bit addressable.
// R15: Wake-up events are separate; interrupts only while core runs.
// R16: An accepted request supplies its fixed vector address.
// R17: Block vectoring one instruction after return or register access; here watchdog control accesses do not block.
// R18: Present only when enabled, globally enabled, no equal level active.
//
// Chosen here: the address-and-strobe port.
`include "irq_ctrl_defs.svh"
module irq_ctrl (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port; bit_sel chooses a single-bit access.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_bit_sel,
  output logic [7:0] reg_rdata,
  // Interrupt sources, synchronous levels.
  input wire logic ext0_irq_source,
  input wire logic timer0_overflow_source,
  input wire logic ext1_irq_source,
  input wire logic timer1_overflow_source,
  input wire logic uart_irq_source,
  input wire logic timer2_irq_source,
  input wire logic serial_port_irq_source,
  input wire logic power_mgmt_irq_source,
  input wire logic meter_irq_source,
  input wire logic rtc_interval_irq_source,
  input wire logic watchdog_irq_source,
  // Core side.
  input wire logic core_off_mode,
  input wire logic core_instr_done,
  input wire logic core_ack,
  input wire logic core_reti,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [3:0] irq_source_id,
  output logic [2:0] active_levels,
  // Watchdog control register contents for the watchdog block.
  output logic [7:0] watchdog_control
);
  import irq_ctrl_pkg::*;

  // Vector of a source index.
  function automatic logic [15:0] vec_of(input irq_src_t s);
    case (s)
      src_power_mgmt: vec_of = `VEC_POWER_MGMT;
      src_rtc: vec_of = `VEC_RTC;
      src_meter: vec_of = `VEC_METER;
      src_watchdog: vec_of = `VEC_WATCHDOG;
      src_ext0: vec_of = `VEC_EXT0;
      src_timer0: vec_of = `VEC_TIMER0;
      src_ext1: vec_of = `VEC_EXT1;
      src_timer1: vec_of = `VEC_TIMER1;
      src_serial_port: vec_of = `VEC_SERIAL_PORT;
      src_uart: vec_of = `VEC_UART;
      src_timer2: vec_of = `VEC_TIMER2;
      default: vec_of = 16'h0000;
    endcase
  endfunction

  // Register update for a byte or single-bit write.
  function automatic logic [7:0] wr_val(input logic [7:0] old,
                                        input logic [7:0] mask,
                                        input logic [7:0] a,
                                        input logic [7:0] d,
                                        input logic bsel);
    logic [7:0] r;
    r = old;
    if (bsel) begin
      r[a[2:0]] = d[0];
    end else begin
      r = d;
    end
    wr_val = r & mask;
  endfunction

  logic [7:0] enable_main_q;
  logic [7:0] priority_main_q;
  logic [7:0] enable_prio2_q;
  logic [7:0] watchdog_q;
  logic [2:0] active_q;
  vec_state_t state_q;
  logic block_q;

  ////////////////////////////////////////////////////////////////////////
  // Address decode. A single-bit access uses the bit address, whose upper
  // five bits name the register; the second register has no bit window.
  logic [7:0] bit_base;
  logic hit_en;
  logic hit_pr;
  logic hit_p2;
  logic hit_wd;
  assign bit_base = {reg_addr[7:3], 3'b000};
  assign hit_en = reg_bit_sel ? (bit_base == `BITBASE_ENABLE_MAIN) :
                  (reg_addr == `OFS_IRQ_ENABLE_MAIN); // R14
  assign hit_pr = reg_bit_sel ? (bit_base == `BITBASE_PRIORITY_MAIN) :
                  (reg_addr == `OFS_IRQ_PRIORITY_MAIN); // R14
  assign hit_wd = reg_bit_sel ? (bit_base == `BITBASE_WATCHDOG) :
                  (reg_addr == `OFS_WATCHDOG_CONTROL); // R14
  assign hit_p2 = !reg_bit_sel &&
                  (reg_addr == `OFS_IRQ_ENABLE_PRIORITY_SECOND); // R14

  // Writes. Reserved bit 6 of the two main registers is kept at zero
  // in hardware as well, so a careless write cannot upset arbitration.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_main_q <= `RST_IRQ_ENABLE_MAIN;
      priority_main_q <= `RST_IRQ_PRIORITY_MAIN;
      enable_prio2_q <= `RST_IRQ_ENABLE_PRIORITY_SECOND;
      watchdog_q <= `RST_WATCHDOG_CONTROL;
    end else if (reg_write) begin
      if (hit_en) begin
        enable_main_q <= wr_val(enable_main_q, `MASK_ENABLE_MAIN,
                                reg_addr, reg_wdata, reg_bit_sel); // R9
      end
      if (hit_pr) begin
        priority_main_q <= wr_val(priority_main_q,
                                  `MASK_PRIORITY_MAIN, reg_addr,
                                  reg_wdata, reg_bit_sel); // R11
      end
      if (hit_p2) begin
        enable_prio2_q <= (reg_wdata & `MASK_ENABLE_PRIORITY_SECOND) |
                          `FIXED_ENABLE_PRIORITY_SECOND; // R13
      end
      if (hit_wd) begin
        watchdog_q <= wr_val(watchdog_q, 8'hff, reg_addr,
                             reg_wdata, reg_bit_sel);
      end
    end
  end

  // Read data one cycle after the strobe; a bit read returns the addressed bit in bit 0.
  logic [7:0] rsel;
  always_comb begin
    rsel = 8'h00;
    if (hit_en) begin
      rsel = enable_main_q;
    end else if (hit_pr) begin
      rsel = priority_main_q;
    end else if (hit_p2) begin
      rsel = enable_prio2_q;
    end else if (hit_wd) begin
      rsel = watchdog_q;
    end
    if (reg_bit_sel) begin
      rsel = {7'h00, rsel[reg_addr[2:0]]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= rsel;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-source request, enable and level in polling order.
  logic [10:0] raw;
  logic [10:0] en;
  logic [10:0] hi;
  assign raw = {timer2_irq_source, uart_irq_source, serial_port_irq_source,
                timer1_overflow_source, ext1_irq_source,
                timer0_overflow_source, ext0_irq_source,
                watchdog_irq_source, meter_irq_source,
                rtc_interval_irq_source, power_mgmt_irq_source}; // R1
  // The watchdog source has no enable bit here and is always enabled.
  assign en = {enable_main_q[`BIT_TIMER2_IRQ_ENABLE],
               enable_main_q[`BIT_UART_IRQ_ENABLE],
               enable_prio2_q[`BIT_SERIAL_PORT_IRQ_ENABLE],
               enable_main_q[`BIT_TIMER1_IRQ_ENABLE],
               enable_main_q[`BIT_EXT1_IRQ_ENABLE],
               enable_main_q[`BIT_TIMER0_IRQ_ENABLE],
               enable_main_q[`BIT_EXT0_IRQ_ENABLE],
               1'b1,
               enable_prio2_q[`BIT_METER_IRQ_ENABLE],
               enable_prio2_q[`BIT_RTC_IRQ_ENABLE],
               enable_prio2_q[`BIT_POWER_MGMT_IRQ_ENABLE]}; // R9 R13
  // Watchdog has no priority bit and sits at the low level.
  assign hi = {priority_main_q[`BIT_TIMER2_IRQ_PRIORITY],
               priority_main_q[`BIT_UART_IRQ_PRIORITY],
               enable_prio2_q[`BIT_SERIAL_PORT_IRQ_PRIORITY],
               priority_main_q[`BIT_TIMER1_IRQ_PRIORITY],
               priority_main_q[`BIT_EXT1_IRQ_PRIORITY],
               priority_main_q[`BIT_TIMER0_IRQ_PRIORITY],
               priority_main_q[`BIT_EXT0_IRQ_PRIORITY],
               1'b0,
               priority_main_q[`BIT_METER_IRQ_PRIORITY],
               enable_prio2_q[`BIT_RTC_IRQ_PRIORITY],
               1'b0}; // R3 R11 R12

  // Gated requests split by level; power management alone is top.
  logic [10:0] live;
  logic [10:0] req_top;
  logic [10:0] req_hi;
  logic [10:0] req_lo;
  assign live = raw & en &
                {11{enable_main_q[`BIT_GLOBAL_IRQ_ENABLE]}} &
                {11{!core_off_mode}}; // R8 R15 R18
  assign req_top = live & 11'h001; // R2
  assign req_hi = live & hi & 11'h7fe; // R3
  assign req_lo = live & ~hi & 11'h7fe; // R3

  // A level may be presented only above every active level.
  logic ok_top;
  logic ok_hi;
  logic ok_lo;
  assign ok_top = !active_q[lvl_top]; // R2 R6
  assign ok_hi = !active_q[lvl_top] && !active_q[lvl_high]; // R4 R6
  assign ok_lo = active_q == 3'b000; // R6 R18

  logic [10:0] pick_in;
  irq_level_t pick_lvl;
  always_comb begin
    pick_in = 11'h000;
    pick_lvl = lvl_low;
    if (ok_top && req_top != 11'h000) begin
      pick_in = req_top;
      pick_lvl = lvl_top;
    end else if (ok_hi && req_hi != 11'h000) begin
      pick_in = req_hi;
      pick_lvl = lvl_high; // R5
    end else if (ok_lo) begin
      pick_in = req_lo;
    end
  end

  logic found;
  irq_src_t winner;
  irq_pick u_pick (
    .req(pick_in),
    .found(found),
    .winner(winner)
  ); // R7

  ////////////////////////////////////////////////////////////////////////
  // Vector offer. An enable or priority register access or a return forces a block state
  // that lasts until the core finishes one more instruction.
  logic reg_touch;
  assign reg_touch = (reg_write || reg_read) && (hit_en || hit_pr || hit_p2);
  irq_level_t offer_lvl_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      block_q <= 1'b0;
    end else if (reg_touch || core_reti) begin
      block_q <= 1'b1; // R17
    end else if (core_instr_done) begin
      block_q <= 1'b0; // R17
    end
  end

  // The offer is withdrawn whenever it is no longer the best choice,
  // so a late higher request replaces it before the core takes it.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= st_idle;
      offer_lvl_q <= lvl_low;
    end else begin
      case (state_q)
        st_idle, st_offer: begin
          if (state_q == st_offer && core_ack) begin
            state_q <= st_block;
          end else if (found && !block_q && !reg_touch && !core_reti) begin
            state_q <= st_offer;
            offer_lvl_q <= pick_lvl;
          end else begin
            state_q <= st_idle;
          end
        end
        default: begin
          state_q <= st_idle; // The block state lasts one cycle.
        end
      endcase
    end
  end

  // Active level stack: ack sets the level, return clears the highest.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= 3'b000;
    end else if (state_q == st_offer && core_ack) begin
      active_q[offer_lvl_q] <= 1'b1; // R4
    end else if (core_reti) begin
      if (active_q[lvl_top]) begin
        active_q[lvl_top] <= 1'b0;
      end else if (active_q[lvl_high]) begin
        active_q[lvl_high] <= 1'b0;
      end else begin
        active_q[lvl_low] <= 1'b0;
      end
    end
  end

  // Outputs straight from flip-flops.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
      irq_vector <= 16'h0000;
      irq_source_id <= 4'hb;
    end else begin
      irq_req <= (state_q != st_block) && !(state_q == st_offer && core_ack)
                 && found && !block_q && !reg_touch && !core_reti;
      irq_vector <= vec_of(winner); // R16
      irq_source_id <= winner;
    end
  end

  assign active_levels = active_q;
  assign watchdog_control = watchdog_q;
endmodule

// >>> verification/irq_ctrl_checker.sv
// Port-level assertions for the interrupt controller.
// Assumes it is bound to irq_ctrl and sees only that module's ports.
`include "irq_ctrl_defs.svh"
module irq_ctrl_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_bit_sel,
  input wire logic [7:0] reg_rdata,
  // Core side.
  input wire logic core_off_mode,
  input wire logic core_instr_done,
  input wire logic core_ack,
  input wire logic core_reti,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0] irq_source_id,
  input wire logic [2:0] active_levels
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Vector expected for each polling index; unknown indexes never match.
  function automatic logic [15:0] vec_of(input logic [3:0] id);
    case (id)
      4'h0: vec_of = `VEC_POWER_MGMT;
      4'h1: vec_of = `VEC_RTC;
      4'h2: vec_of = `VEC_METER;
      4'h3: vec_of = `VEC_WATCHDOG;
      4'h4: vec_of = `VEC_EXT0;
      4'h5: vec_of = `VEC_TIMER0;
      4'h6: vec_of = `VEC_EXT1;
      4'h7: vec_of = `VEC_TIMER1;
      4'h8: vec_of = `VEC_SERIAL_PORT;
      4'h9: vec_of = `VEC_UART;
      4'ha: vec_of = `VEC_TIMER2;
      default: vec_of = 16'hffff;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // A byte access to an enable or priority register, and a vector taken.
  logic acc;
  logic blk_q;
  assign acc = (reg_write || reg_read) && !reg_bit_sel &&
    (reg_addr == `OFS_IRQ_ENABLE_MAIN ||
     reg_addr == `OFS_IRQ_PRIORITY_MAIN ||
     reg_addr == `OFS_IRQ_ENABLE_PRIORITY_SECOND);
  sequence took_s;
    core_ack && irq_req;
  endsequence

  // Block window rebuilt from the ports: set by such an access or a
  // return, cleared by a finished instruction; a new access wins a tie.
  // Bit accesses block in the design too, so this window is a subset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blk_q <= 1'b0;
    end else if (acc || core_reti) begin
      blk_q <= 1'b1;
    end else if (core_instr_done) begin
      blk_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Inside the window the offer must be down from the next edge on.
  reg_block_a: assert property (blk_q |=> !irq_req)
    else $error("offer during access block");
  off_quiet_a: assert property (core_off_mode |=> !irq_req)
    else $error("offer while core is off");
  ack_drop_a: assert property (took_s |=> !irq_req [*2])
    else $error("offer did not drop after ack");
  vec_map_a: assert property (irq_req |->
    irq_vector == vec_of(irq_source_id))
    else $error("vector does not match source");
  rdata_idle_a: assert property (!$past(reg_read) |->
    reg_rdata == 8'h00)
    else $error("read data outside read answer");
  top_alone_a: assert property (active_levels[2] |-> !irq_req)
    else $error("offer during top level routine");
  high_nest_a: assert property (irq_req && active_levels[1] |->
    irq_source_id == 4'h0)
    else $error("non top offer during high routine");
  pm_nest_a: assert property (took_s ##0 irq_source_id == 4'h0 |=>
    active_levels == ($past(active_levels) | 3'b100))
    else $error("top level not marked active");
  reti_pop_a: assert property (core_reti && !core_ack &&
    active_levels == 3'b011 |=> active_levels == 3'b001)
    else $error("return did not clear high level");
endmodule

// >>> verification/core_model.sv
// Behavioural core that takes offered vectors and returns on request.
// Assumes the controller's clock; the bench asks for returns by ret_go.
module core_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Offer from the controller and return request from the bench.
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic ret_go,
  // Core handshake.
  output logic core_instr_done,
  output logic core_ack,
  output logic core_reti,
  // Last vector taken and how many were taken.
  output logic [15:0] taken_vec,
  output logic [7:0] taken_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] step_q;

  // An instruction ends every fourth cycle, so blocks never last long.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step_q <= 2'h0;
      core_instr_done <= 1'b0;
    end else begin
      step_q <= step_q + 2'h1;
      core_instr_done <= (step_q == 2'h3);
    end
  end

  // Ack is a single pulse; a second is held off while the offer drops.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_ack <= 1'b0;
      core_reti <= 1'b0;
      taken_vec <= 16'h0000;
      taken_cnt <= 8'h00;
    end else begin
      core_ack <= irq_req && !core_ack;
      core_reti <= ret_go;
      if (core_ack && irq_req) begin
        taken_vec <= irq_vector;
        taken_cnt <= taken_cnt + 8'h01;
      end
    end
  end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the interrupt controller with a core model.
// Assumes the design, its package and its header are compiled first.
`include "irq_ctrl_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Vectors in polling order, index 0 first.
  localparam logic [15:0] VT [11] = '{`VEC_POWER_MGMT, `VEC_RTC,
    `VEC_METER, `VEC_WATCHDOG, `VEC_EXT0, `VEC_TIMER0, `VEC_EXT1,
    `VEC_TIMER1, `VEC_SERIAL_PORT, `VEC_UART, `VEC_TIMER2};
  logic clk, rst_b, reg_write, reg_read, reg_bit_sel, core_off_mode;
  logic core_instr_done, core_ack, core_reti, irq_req, ret_go;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, watchdog_control, taken_cnt;
  logic [10:0] src;
  logic [15:0] irq_vector, taken_vec;
  logic [3:0] irq_source_id;
  logic [2:0] active_levels;
  int failures, num_checks, cyc;

  irq_ctrl DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_bit_sel(reg_bit_sel), .reg_rdata(reg_rdata),
    .ext0_irq_source(src[4]), .timer0_overflow_source(src[5]),
    .ext1_irq_source(src[6]), .timer1_overflow_source(src[7]),
    .uart_irq_source(src[9]), .timer2_irq_source(src[10]),
    .serial_port_irq_source(src[8]), .power_mgmt_irq_source(src[0]),
    .meter_irq_source(src[2]), .rtc_interval_irq_source(src[1]),
    .watchdog_irq_source(src[3]), .core_off_mode(core_off_mode),
    .core_instr_done(core_instr_done), .core_ack(core_ack),
    .core_reti(core_reti), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_source_id(irq_source_id), .active_levels(active_levels),
    .watchdog_control(watchdog_control));
  core_model core (.clk(clk), .rst_b(rst_b), .irq_req(irq_req),
    .irq_vector(irq_vector), .ret_go(ret_go),
    .core_instr_done(core_instr_done), .core_ack(core_ack),
    .core_reti(core_reti), .taken_vec(taken_vec), .taken_cnt(taken_cnt));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the run needs far fewer cycles than the limit.
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic b);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_bit_sel <= b;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_bit_sel <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk("rdata", 16'(reg_rdata), 16'(e));
  endtask
  task automatic setsrc(input logic [10:0] v);
    @(posedge clk);
    src <= v;
  endtask
  task automatic ret();
    @(posedge clk);
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
  endtask
  // Waits a bounded time for the core to take a vector.
  task automatic serve(input logic [15:0] v);
    logic [7:0] n;
    int k;
    n = taken_cnt;
    k = 0;
    while (taken_cnt === n && k < 40) begin
      @(posedge clk);
      k++;
    end
    #1 chk("vector", taken_vec, v);
    chk("count", 16'(taken_cnt - n), 16'h0001);
  endtask
  task automatic quiet();
    logic [7:0] n;
    n = taken_cnt;
    repeat (12) @(posedge clk);
    chk("taken", 16'(taken_cnt), 16'(n));
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(8'ha8, 8'h00);
    rd(8'ha9, 8'ha0);
    rd(8'hb8, 8'h00);
    rd(8'hc0, 8'h10);
    rd(8'h55, 8'h00);
    chk("watchdog_control", 16'(watchdog_control), 16'h0010);
    wr(8'hc2, 8'h01, 1'b1);
    rd(8'hc0, 8'h14);
    chk("watchdog_control", 16'(watchdog_control), 16'h0014);
    wr(8'ha9, 8'h5f, 1'b0);
    rd(8'ha9, 8'hff);
    wr(8'ha9, 8'h0f, 1'b0);
    rd(8'ha9, 8'haf);
    wr(8'ha8, 8'hbf, 1'b0);
    rd(8'ha8, 8'hbf);
    wr(8'ha8, 8'h00, 1'b0);
    wr(8'haf, 8'h01, 1'b1);
    rd(8'ha8, 8'h80);
    wr(8'hbf, 8'h01, 1'b1);
    rd(8'hb8, 8'h80);
    wr(8'hb8, 8'h00, 1'b0);
  endtask
  task automatic t_global();
    wr(8'ha8, 8'h01, 1'b0);
    setsrc(11'h010);
    quiet();
    wr(8'ha8, 8'hbf, 1'b0);
    serve(VT[4]);
    setsrc(11'h000);
    ret();
  endtask
  // All but the top source at once: served in polling order.
  task automatic t_order();
    setsrc(11'h7fe);
    for (int i = 1; i < 11; i++) begin
      serve(VT[i]);
      quiet();
      setsrc(src & ~(11'h001 << i));
      ret();
    end
  endtask
  task automatic t_nest();
    wr(8'hb8, 8'h02, 1'b0);
    setsrc(11'h010);
    serve(VT[4]);
    setsrc(11'h030);
    serve(VT[5]);
    setsrc(11'h031);
    serve(VT[0]);
    chk("active", 16'(active_levels), 16'h0007);
    setsrc(11'h000);
    ret();
    ret();
    ret();
    repeat (4) @(posedge clk);
    chk("active", 16'(active_levels), 16'h0000);
  endtask
  task automatic t_same();
    wr(8'ha9, 8'h4f, 1'b0);
    setsrc(11'h030);
    serve(VT[5]);
    quiet();
    setsrc(11'h010);
    ret();
    serve(VT[4]);
    setsrc(11'h012);
    serve(VT[1]);
    setsrc(11'h000);
    ret();
    ret();
  endtask
  task automatic t_off();
    @(posedge clk);
    core_off_mode <= 1'b1;
    setsrc(11'h010);
    quiet();
    core_off_mode <= 1'b0;
    serve(VT[4]);
    setsrc(11'h000);
    ret();
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Reset for three cycles, then the scenarios in turn.
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {reg_write, reg_read, reg_bit_sel, core_off_mode, ret_go} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    src = 11'h000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_global();
    t_order();
    t_nest();
    t_same();
    t_off();
    print_verdict();
  end
endmodule

bind irq_ctrl irq_ctrl_checker chk_i (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
  .reg_bit_sel(reg_bit_sel), .reg_rdata(reg_rdata),
  .core_off_mode(core_off_mode), .core_instr_done(core_instr_done),
  .core_ack(core_ack), .core_reti(core_reti), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_source_id(irq_source_id),
  .active_levels(active_levels));
